/* design/sifb_flag_bank.sv */
// special interrupt flag bank with AHB-Lite register access and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "sifb_regs.svh"

// Behaviour
// - watchdog overflow or key violation sets bit0
// - watchdog flag cleared only by power-up/pin reset or the bus reset (hresetn)
// - oscillator fault sets bit1, set after clear
// - pin NMI sets bit4, clear after clear
// - serial0 tx ready flag, variant placed, set
// - serial1 tx ready at second bit5, set
// - initial states applied at power-up clear
module sifb_flag_bank #(
  parameter logic [1:0] VARIANT = `SIFB_VAR_TWO
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire sifb_pkg::sifb_events_s events,
  input wire sifb_pkg::sifb_resets_s resets,
  output logic irq
);
  import sifb_pkg::*;

  // variant codes: basic has no serial port, the small one keeps its port flags
  // in the second register, the big one in the first, and the two-port variant
  // adds the second port's flags to the second register

  // one-hot bit at a position
  function automatic logic [7:0] onehot(input int pos);
    onehot = 8'h01 << pos;
  endfunction : onehot

  // bits of the first register that exist on a variant
  function automatic logic [7:0] impl_first(input logic [1:0] v);
    logic [7:0] r;
    r = onehot(`SIFB_BIT_WDT) | onehot(`SIFB_BIT_OSC) | onehot(`SIFB_BIT_NMI);
    case (v)
      `SIFB_VAR_ONE_BIG, `SIFB_VAR_TWO: begin
        r = r | onehot(`SIFB_BIT_RX0_BIG) | onehot(`SIFB_BIT_TX0_BIG);
      end
      default: begin
        r = r;
      end
    endcase
    return r;
  endfunction : impl_first

  // bits of the second register that exist on a variant
  function automatic logic [7:0] impl_second(input logic [1:0] v);
    logic [7:0] r;
    case (v)
      `SIFB_VAR_ONE_SMALL: begin
        r = onehot(`SIFB_BIT_RX0_SMALL) | onehot(`SIFB_BIT_TX0_SMALL);
      end
      `SIFB_VAR_TWO: begin
        r = onehot(`SIFB_BIT_RX1) | onehot(`SIFB_BIT_TX1);
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : impl_second

  // first register contents right after a power-up clear
  function automatic logic [7:0] init_first(input logic [1:0] v);
    logic [7:0] r;
    r = onehot(`SIFB_BIT_OSC);
    case (v)
      `SIFB_VAR_ONE_BIG, `SIFB_VAR_TWO: begin
        r = r | onehot(`SIFB_BIT_TX0_BIG);
      end
      default: begin
        r = r;
      end
    endcase
    return r;
  endfunction : init_first

  // second register contents right after a power-up clear
  function automatic logic [7:0] init_second(input logic [1:0] v);
    logic [7:0] r;
    case (v)
      `SIFB_VAR_ONE_SMALL: begin
        r = onehot(`SIFB_BIT_TX0_SMALL);
      end
      `SIFB_VAR_TWO: begin
        r = onehot(`SIFB_BIT_TX1);
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : init_second

  // event pulses that land in the first register
  function automatic logic [7:0] set_first(input sifb_events_s ev, input logic [1:0] v);
    logic [7:0] r;
    r = {8{ev.wdt_event}} & onehot(`SIFB_BIT_WDT);
    r = r | ({8{ev.osc_fault}} & onehot(`SIFB_BIT_OSC));
    r = r | ({8{ev.nmi_event}} & onehot(`SIFB_BIT_NMI));
    case (v)
      `SIFB_VAR_ONE_BIG, `SIFB_VAR_TWO: begin
        r = r | ({8{ev.rx0_char}} & onehot(`SIFB_BIT_RX0_BIG));
        r = r | ({8{ev.tx0_ready}} & onehot(`SIFB_BIT_TX0_BIG));
      end
      default: begin
        r = r;
      end
    endcase
    return r;
  endfunction : set_first

  // event pulses that land in the second register
  function automatic logic [7:0] set_second(input sifb_events_s ev, input logic [1:0] v);
    logic [7:0] r;
    case (v)
      `SIFB_VAR_ONE_SMALL: begin
        r = {8{ev.rx0_char}} & onehot(`SIFB_BIT_RX0_SMALL);
        r = r | ({8{ev.tx0_ready}} & onehot(`SIFB_BIT_TX0_SMALL));
      end
      `SIFB_VAR_TWO: begin
        r = {8{ev.rx1_char}} & onehot(`SIFB_BIT_RX1);
        r = r | ({8{ev.tx1_ready}} & onehot(`SIFB_BIT_TX1));
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : set_second

  // per-variant patterns, fixed at elaboration so the flag logic stays flat
  localparam logic [7:0] IMPL_FIRST = impl_first(VARIANT);
  localparam logic [7:0] IMPL_SECOND = impl_second(VARIANT);
  localparam logic [7:0] INIT_FIRST = init_first(VARIANT);
  localparam logic [7:0] INIT_SECOND = init_second(VARIANT);
  localparam logic [7:0] WDT_BIT = onehot(`SIFB_BIT_WDT);

  // register state and next values
  logic [7:0] flags1_q;
  logic [7:0] flags1_d;
  logic [7:0] flags2_q;
  logic [7:0] flags2_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] set1;
  logic [7:0] set2;
  // bus side decode
  logic [11:0] addr_q;
  sifb_phase_e phase_q;
  logic [7:0] wdata;
  logic wr_f1;
  logic wr_f2;
  logic wr_st;
  logic wr_mask;
  logic wr_ctrl;
  logic any_clear;
  logic [31:0] rd_d;

  // event pulses mapped onto the two registers
  assign set1 = set_first(events, VARIANT);
  assign set2 = set_second(events, VARIANT);

  // write strobes of the data phase
  assign wdata = hwdata[7:0];
  assign wr_f1 = (phase_q == SIFB_WRITE) && (addr_q == `SIFB_OFF_FLAGS1);
  assign wr_f2 = (phase_q == SIFB_WRITE) && (addr_q == `SIFB_OFF_FLAGS2);
  assign wr_st = (phase_q == SIFB_WRITE) && (addr_q == `SIFB_OFF_IRQ_STAT);
  assign wr_mask = (phase_q == SIFB_WRITE) && (addr_q == `SIFB_OFF_IRQ_MASK);
  assign wr_ctrl = (phase_q == SIFB_WRITE) && (addr_q == `SIFB_OFF_CTRL);
  // both reset sources load the initial states; the bus reset alone does not
  assign any_clear = resets.power_up_clear | resets.rst_pin_reset;

  // address phase capture; zero wait states, whole-word transfers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= SIFB_IDLE;
      addr_q <= 12'h000;
    end else if (hready) begin
      addr_q <= haddr[11:0];
      if (hsel && htrans[1]) begin
        phase_q <= hwrite ? SIFB_WRITE : SIFB_READ;
      end else begin
        phase_q <= SIFB_IDLE;
      end
    end
  end

  // first flag register next value; reset sources beat events, events beat a write
  always_comb begin
    if (any_clear) begin
      flags1_d = INIT_FIRST & IMPL_FIRST;
    end else begin
      flags1_d = wr_f1 ? wdata : flags1_q;
      // software may raise the watchdog flag but never clears it
      flags1_d = flags1_d | (flags1_q & WDT_BIT);
      flags1_d = (flags1_d | set1) & IMPL_FIRST;
    end
  end

  // first flag register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags1_q <= `SIFB_FLAGS1_RESET;
    end else begin
      flags1_q <= flags1_d;
    end
  end

  // second flag register next value
  always_comb begin
    if (any_clear) begin
      flags2_d = INIT_SECOND & IMPL_SECOND;
    end else begin
      flags2_d = ((wr_f2 ? wdata : flags2_q) | set2) & IMPL_SECOND;
    end
  end

  // second flag register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags2_q <= `SIFB_FLAGS2_RESET;
    end else begin
      flags2_q <= flags2_d;
    end
  end

  // sticky event status, write one to clear; a new event wins over the clear
  always_comb begin
    stat_d = stat_q & ~(wr_st ? wdata : 8'h00);
    stat_d = (stat_d | set1) & IMPL_FIRST;
  end

  // event status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= `SIFB_STAT_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  // mask and scratch control take the written byte as it is
  always_comb begin
    mask_d = wr_mask ? wdata : mask_q;
    ctrl_d = wr_ctrl ? wdata : ctrl_q;
  end

  // mask and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `SIFB_MASK_RESET;
      ctrl_q <= `SIFB_CTRL_RESET;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  // read mux for the address phase; it looks at next values so that a read
  // right behind a write's data phase already sees the written byte
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[11:0])
      `SIFB_OFF_FLAGS1: rd_d = {24'h000000, flags1_d};
      `SIFB_OFF_FLAGS2: rd_d = {24'h000000, flags2_d};
      `SIFB_OFF_IRQ_STAT: rd_d = {24'h000000, stat_d};
      `SIFB_OFF_IRQ_MASK: rd_d = {24'h000000, mask_d};
      `SIFB_OFF_CTRL: rd_d = {24'h000000, ctrl_d};
      default: rd_d = 32'h0000_0000; // unmapped reads give zero
    endcase
  end

  // registered bus answers and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_d;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(stat_q & mask_q);
    end
  end

endmodule : sifb_flag_bank
`default_nettype wire

/* design/sifb_pkg.sv */
// types shared by the special interrupt flag bank
package sifb_pkg;

  // event inputs from the system modules, each a one-cycle pulse
  typedef struct packed {
    logic wdt_event;
    logic osc_fault;
    logic nmi_event;
    logic rx0_char;
    logic tx0_ready;
    logic rx1_char;
    logic tx1_ready;
  } sifb_events_s;

  // the two power-up-clear style resets
  typedef struct packed {
    logic power_up_clear;
    logic rst_pin_reset;
  } sifb_resets_s;

  typedef enum logic [1:0] {
    SIFB_IDLE = 2'b00,
    SIFB_WRITE = 2'b01,
    SIFB_READ = 2'b10
  } sifb_phase_e;

endpackage : sifb_pkg

/* design/sifb_regs.svh */
// register offsets, bit positions, reset values and variant codes for the flag bank
`ifndef SIFB_REGS_SVH
`define SIFB_REGS_SVH

`define SIFB_OFF_FLAGS1 12'h000
`define SIFB_OFF_FLAGS2 12'h004
`define SIFB_OFF_IRQ_STAT 12'h008
`define SIFB_OFF_IRQ_MASK 12'h00C
`define SIFB_OFF_CTRL 12'h010

`define SIFB_BIT_WDT 0
`define SIFB_BIT_OSC 1
`define SIFB_BIT_NMI 4
`define SIFB_BIT_RX0_BIG 6
`define SIFB_BIT_TX0_BIG 7
`define SIFB_BIT_RX0_SMALL 0
`define SIFB_BIT_TX0_SMALL 1
`define SIFB_BIT_RX1 4
`define SIFB_BIT_TX1 5

`define SIFB_VAR_BASIC 2'h0
`define SIFB_VAR_ONE_SMALL 2'h1
`define SIFB_VAR_ONE_BIG 2'h2
`define SIFB_VAR_TWO 2'h3

`define SIFB_CTRL_RESET 8'h00
`define SIFB_MASK_RESET 8'h00
`define SIFB_FLAGS1_RESET 8'h02
`define SIFB_FLAGS2_RESET 8'h00
`define SIFB_STAT_RESET 8'h00

`endif

/* tb/sifb_flag_bank_bench.sv */
// self-checking bench for the flag bank
`timescale 1ns/10ps
`default_nettype none
module sifb_flag_bank_bench;
  import sifb_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic rd_dph = 1'b0;
  sifb_events_s events = '0;
  sifb_resets_s resets = '0;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  sifb_flag_bank #(.VARIANT(2'h3)) sifb_flag_bank_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .events, .resets, .irq);
  always #2.5 hclk = ~hclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // one transfer; for a read, d is the expected data and is noted
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : xfer
  task automatic pulse(input logic [6:0] e, input logic [1:0] r);
    @(posedge hclk);
    events <= e;
    resets <= r;
    @(posedge hclk);
    events <= '0;
    resets <= '0;
  endtask : pulse
  // irq is registered, so give it two edges to settle
  task automatic irqchk(input logic e);
    repeat (2) @(posedge hclk);
    #1 chk("irq", e, irq);
  endtask : irqchk
  // read data taken at the edge closing each data phase; also the hang limit
  always @(posedge hclk) begin
    cyc++;
    if (rd_dph) chk("hrdata", exp_q.pop_front(), hrdata);
    rd_dph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    rnd = $urandom(32'hED9C8F0E);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    pulse(7'h00, 2'h2);
    xfer(1'b0, 32'h0, 32'h82);
    pulse(7'h00, 2'h2);
    xfer(1'b0, 32'h4, 32'h20);
    xfer(1'b0, 32'h100, 32'h0);
    $display("test initial states done");
    pulse(7'h5A, 2'h0);
    xfer(1'b0, 32'h0, 32'hD3);
    xfer(1'b0, 32'h4, 32'h30);
    xfer(1'b1, 32'h0, 32'hFF);
    xfer(1'b0, 32'h0, 32'hD3);
    xfer(1'b1, 32'h0, 32'h00);
    xfer(1'b0, 32'h0, 32'h01);
    pulse(7'h24, 2'h0);
    xfer(1'b0, 32'h0, 32'h83);
    pulse(7'h00, 2'h1);
    xfer(1'b0, 32'h0, 32'h82);
    $display("test flag events done");
    xfer(1'b1, 32'h8, 32'hFF);
    xfer(1'b1, 32'hC, 32'h10);
    pulse(7'h10, 2'h0);
    xfer(1'b0, 32'h8, 32'h10);
    irqchk(1'b1);
    xfer(1'b1, 32'hC, 32'h00);
    irqchk(1'b0);
    xfer(1'b1, 32'hC, 32'h10);
    irqchk(1'b1);
    xfer(1'b1, 32'h8, 32'h10);
    irqchk(1'b0);
    $display("test interrupt done");
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom();
      xfer(1'b1, 32'h10, rnd);
      xfer(1'b0, 32'h10, {24'h0, rnd[7:0]});
    end
    $display("test scratch done");
    repeat (2) @(posedge hclk);
    finish_test();
  end
endmodule : sifb_flag_bank_bench
`default_nettype wire

/* tb/sifb_flag_bank_properties.sv */
// checker on the flag bank's top-level ports
`timescale 1ns/10ps
`default_nettype none
module sifb_props_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire sifb_pkg::sifb_events_s events,
  input wire sifb_pkg::sifb_resets_s resets
);
  import sifb_pkg::*;
  logic rd1;
  logic rd2;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phases of the two flag registers
  assign rd1 = hsel && hready && htrans[1] && !hwrite && (haddr == 32'h0);
  assign rd2 = hsel && hready && htrans[1] && !hwrite && (haddr == 32'h4);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
  chk_unimpl_first: assert property (rd1 |=> (hrdata[7:0] & 8'h2C) == 8'h0)
    else $error("first register spare bits set");
  chk_unimpl_second: assert property (rd2 |=> (hrdata[7:0] & 8'hCF) == 8'h0)
    else $error("second register spare bits set");
  chk_init_first: assert property (resets.power_up_clear ##2 rd1 |=> hrdata[7:0] == 8'h82)
    else $error("first register initial value wrong");
  chk_init_second: assert property (resets.power_up_clear ##2 rd2 |=> hrdata[7:0] == 8'h20)
    else $error("second register initial value wrong");
  chk_wdt_sets: assert property (events.wdt_event ##2 rd1 |=> hrdata[0])
    else $error("watchdog flag not set");
  chk_nmi_sets: assert property (events.nmi_event ##2 rd1 |=> hrdata[4])
    else $error("pin event flag not set");
  chk_pin_clears: assert property (resets.rst_pin_reset ##2 rd1 |=> !hrdata[0])
    else $error("watchdog flag survived pin reset");
endmodule : sifb_props_chk
bind sifb_flag_bank sifb_props_chk sifb_props_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .events, .resets);
`default_nettype wire
